// ### src/adsp_pkg.sv
package adsp_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int LINK_PERIOD_NS = 80;
    // Serial clock half period in system clocks
    localparam int SCLK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // Frame layout
    // ---------------------------------------------------------------
    localparam int FRAME_BITS  = 16;
    localparam int NUM_REGS    = 18;
    localparam int PAR_SAMPLES = 6;   // samples taken before the parity bit
    localparam int FR_RW_BIT   = 15;
    localparam int FR_ADDR_LSB = 10;
    localparam int FR_PAR_BIT  = 9;
    localparam logic [4:0] CNT_SAT = 5'h1f;

    // ---------------------------------------------------------------
    // Register map (index = register_address_field)
    // ---------------------------------------------------------------
    localparam logic [4:0] A_CTRL   = 5'h00;
    localparam logic [4:0] A_HBDRV  = 5'h01;
    localparam logic [4:0] A_HSDRV  = 5'h02;
    localparam logic [4:0] A_HBSTAT = 5'h03;
    localparam logic [4:0] A_HSSTAT = 5'h04;
    localparam logic [4:0] A_HALL   = 5'h07;
    localparam logic [4:0] A_AMUX   = 5'h08;
    localparam logic [4:0] A_IMASK  = 5'h09;
    localparam logic [4:0] A_IFLAG  = 5'h0a;
    localparam logic [4:0] A_WDOG   = 5'h0b;
    localparam logic [4:0] A_STATUS = 5'h0c;
    localparam logic [4:0] A_TRIM1  = 5'h0f;
    localparam logic [4:0] A_TRIM2  = 5'h10;
    localparam logic [4:0] A_TRIM3  = 5'h11;
    localparam logic [7:0] REG_RST  = 8'h00;

    // Writable and readable bit masks
    localparam logic [7:0] M_ALL    = 8'hff;
    localparam logic [7:0] M_NONE   = 8'h00;
    localparam logic [7:0] M_CTRL   = 8'h9f;
    localparam logic [7:0] M_HSDRV  = 8'hbf;
    localparam logic [7:0] M_HBSTAT = 8'h80;
    localparam logic [7:0] M_HSSTAT = 8'h87;
    localparam logic [7:0] M_HALL   = 8'h07;
    localparam logic [7:0] M_IFLAG  = 8'hef;
    localparam logic [7:0] M_WD_EN  = 8'h80;
    localparam logic [7:0] M_WD_PER = 8'h60;
    localparam logic [7:0] M_TRIM1W = 8'hcf;
    localparam logic [7:0] M_TRIM1R = 8'hc0;
    localparam logic [7:0] M_SYSFLG = 8'h9e;
    localparam int WD_CLR_BIT = 0;
    localparam int IF_TEMP    = 3;
    localparam int IF_UNDV    = 2;
    localparam int IF_OVRV    = 1;
    localparam int SS_TEMP    = 6;
    localparam int SS_VF      = 5;

    // ---------------------------------------------------------------
    // Host controller registers (byte offsets)
    // ---------------------------------------------------------------
    localparam logic [3:0] H_CMD   = 4'h0;
    localparam logic [3:0] H_STAT  = 4'h4;
    localparam logic [3:0] H_ISTAT = 4'h8;
    localparam logic [3:0] H_IMASK = 4'hc;
    localparam int CMD_RW_BIT   = 13;
    localparam int CMD_ADDR_LSB = 8;
    localparam int ST_BUSY_BIT  = 16;
endpackage : adsp_pkg

// ### src/adsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adsp_if;
    logic ss_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Undriven line reads as low, like a weak pull-down
    assign miso_line = miso_oe & miso;

    modport dev  (input ss_n, sclk, mosi, output miso, miso_oe);
    modport host (output ss_n, sclk, mosi, input miso_line);
endinterface : adsp_if
`default_nettype wire

// ### src/adsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adsp_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_i, // System clock
    input  wire logic         rst_i, // Synchronous reset
    input  wire logic [W-1:0] d_i,   // Asynchronous inputs
    output logic      [W-1:0] q_o    // Synchronised outputs
);
    logic [W-1:0] meta;

    // ---------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= INIT;
            q_o  <= INIT;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : adsp_sync
`default_nettype wire

// ### src/adsp_device.sv
// Functional notes
// R1 - Frame is address byte then data byte
// R2 - Select fall starts frame, enables MISO
// R3 - Outputs change on serial clock rise
// R4 - Inputs sampled on serial clock fall
// R5 - Valid only with exactly 16 samples
// R6 - Write lands at select rising edge
// R7 - Register read captured at parity bit
// R8 - Select high releases MISO
// R9 - Five-bit register address selects register
// R10 - Read: ignore data, return register
// R11 - Write: return value before write
// R12 - Master makes address parity even
// R13 - Parity checked on writes only
// R14 - First returned byte is system status
// R15 - Last address bit ignored
// R16 - Watchdog clear acts at select rise
// R17 - MSB first; direction, address, parity, spare
// R18 - Bad frames change no register
// R19 - Reserved reads zero, read-only unwritable
`timescale 1ns/1ps
`default_nettype none
module adsp_device import adsp_pkg::*; #(
    parameter int NREG = NUM_REGS
) (
    input  wire logic            clk_i,      // System clock
    input  wire logic            rst_i,      // Synchronous reset
    adsp_if.dev                  link,       // Serial link
    input  wire logic [7:0]      event_i,    // Sets interrupt_flags bits
    input  wire logic [7:0]      sys_flag_i, // Live system_status flags
    input  wire logic [7:0]      hs_flag_i,  // Live high-side status
    output logic      [NREG*8-1:0] regs_o,   // Register contents
    output logic                 wd_clear_o, // Watchdog restart pulse
    output logic                 irq_o       // Unmasked flag pending
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FRAME = 2'b10} adsp_dstate_t;

    adsp_dstate_t state;
    logic         ss_s, sck_s, mosi_s, ss_q, sck_q;
    logic         ss_fall, ss_rise, sck_rise, sck_fall;
    logic [4:0]   smp_cnt, rise_cnt;
    logic [15:0]  rx_sr;
    logic [7:0]   stat_cap, data_cap, rd_val, sys_status;
    logic         commit;
    logic [4:0]   waddr;
    logic [7:0]   regs      [NREG];
    logic [7:0]   next_regs [NREG];

    // ---------------------------------------------------------------
    // Per-register writable bits
    // ---------------------------------------------------------------
    function automatic logic [7:0] wmask(input logic [4:0] a);
        if (a == A_CTRL)        wmask = M_CTRL;
        else if (a == A_HBDRV || a == A_AMUX || a == A_IMASK) wmask = M_ALL;
        else if (a == A_TRIM2 || a == A_TRIM3) wmask = M_ALL;
        else if (a == A_HSDRV)  wmask = M_HSDRV;
        else if (a == A_HBSTAT) wmask = M_HBSTAT;
        else if (a == A_HALL)   wmask = M_HALL;
        else if (a == A_TRIM1)  wmask = M_TRIM1W;
        else                    wmask = M_NONE;
    endfunction : wmask

    // Readable bits; write-only trims and spare bits read zero
    function automatic logic [7:0] rmask(input logic [4:0] a);
        if (a == A_TRIM1)       rmask = M_TRIM1R;
        else if (a == A_TRIM2 || a == A_TRIM3) rmask = M_NONE;
        else if (a == A_IFLAG)  rmask = M_IFLAG;
        else if (a == A_WDOG)   rmask = M_WD_EN | M_WD_PER;
        else                    rmask = wmask(a);
    endfunction : rmask

    // ---------------------------------------------------------------
    // Link input synchronisation and edge detection
    // ---------------------------------------------------------------
    adsp_sync #(.W(3), .INIT(3'h4)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({link.ss_n, link.sclk, link.mosi}),
        .q_o   ({ss_s, sck_s, mosi_s})
    );

    // Previous sampled levels for edge finding
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ss_q  <= 1'b1;
            sck_q <= 1'b0;
        end
        else
        begin
            ss_q  <= ss_s;
            sck_q <= sck_s;
        end
    end

    assign ss_fall  = ss_q & ~ss_s;
    assign ss_rise  = ~ss_q & ss_s;
    assign sck_rise = ~sck_q & sck_s & (state == ST_FRAME);
    assign sck_fall = sck_q & ~sck_s & (state == ST_FRAME);

    // ---------------------------------------------------------------
    // Frame state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:  if (ss_fall) state <= ST_FRAME; // see R2
                ST_FRAME: if (ss_rise) state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Receive path: sample counter and shift register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            smp_cnt <= 5'h00;
            rx_sr   <= 16'h0000;
        end
        else if (ss_fall)
            smp_cnt <= 5'h00;
        else if (sck_fall)
        begin
            // Saturate so overlong frames never wrap back to 16
            if (smp_cnt != CNT_SAT)
                smp_cnt <= smp_cnt + 5'h01;
            rx_sr <= {rx_sr[14:0], mosi_s}; // see R4 see R17
        end
    end

    // ---------------------------------------------------------------
    // Transmit path: status at frame start, data at parity bit
    // ---------------------------------------------------------------
    assign sys_status = (sys_flag_i & M_SYSFLG)
                      | ({7'h00, regs[A_IFLAG][IF_TEMP]} << SS_TEMP)
                      | ({7'h00, regs[A_IFLAG][IF_UNDV] | regs[A_IFLAG][IF_OVRV]} << SS_VF);

    // Read value of the addressed register
    always_comb
    begin
        if (rx_sr[4:0] == A_STATUS)
            rd_val = sys_status;
        else if (rx_sr[4:0] == A_HSSTAT)
            rd_val = hs_flag_i & M_HSSTAT;
        else if (rx_sr[4:0] < 5'(NREG))
            rd_val = regs[rx_sr[4:0]] & rmask(rx_sr[4:0]); // see R19
        else
            rd_val = 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_cap <= 8'h00;
            data_cap <= 8'h00;
        end
        else
        begin
            if (ss_fall)
                stat_cap <= sys_status; // see R14
            // rx_sr holds direction and address while parity arrives
            if (sck_fall && smp_cnt == 5'(PAR_SAMPLES))
                data_cap <= rd_val; // see R7 see R9 see R10 see R11
        end
    end

    // Bit counter of rising edges and MISO drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rise_cnt  <= 5'h00;
            link.miso <= 1'b0;
        end
        else if (ss_fall)
            rise_cnt <= 5'h00;
        else if (sck_rise)
        begin
            if (rise_cnt != CNT_SAT)
                rise_cnt <= rise_cnt + 5'h01;
            // see R1 see R3
            if (rise_cnt < 5'(FRAME_BITS))
                link.miso <= (rise_cnt[3] ? data_cap[~rise_cnt[2:0]]
                                          : stat_cap[~rise_cnt[2:0]]);
            else
                link.miso <= 1'b0;
        end
    end

    // Driver enabled while synchronised select is low, one cycle after it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            link.miso_oe <= 1'b0;
        else
            link.miso_oe <= ~ss_s; // see R2 see R8
    end

    // ---------------------------------------------------------------
    // Frame commit; bit 8 of the address byte is never looked at
    // ---------------------------------------------------------------
    // see R5 see R13 see R15 see R18
    assign commit = (state == ST_FRAME) && ss_rise && smp_cnt == 5'(FRAME_BITS)
                  && !rx_sr[FR_RW_BIT] && !(^rx_sr[FR_RW_BIT:FR_PAR_BIT]);
    assign waddr  = rx_sr[FR_ADDR_LSB+4:FR_ADDR_LSB];

    always_comb
    begin
        next_regs = regs;
        if (commit && waddr < 5'(NREG)) // see R6
        begin
            if (waddr == A_IFLAG)
                next_regs[waddr] = regs[waddr] & ~rx_sr[7:0];
            else if (waddr == A_WDOG)
                // Enable is set-only; period bits overwrite
                next_regs[waddr] = ((regs[waddr] | rx_sr[7:0]) & M_WD_EN)
                                 | (rx_sr[7:0] & M_WD_PER);
            else
                next_regs[waddr] = (regs[waddr] & ~wmask(waddr))
                                 | (rx_sr[7:0] & wmask(waddr));
        end
        // Events applied after the clear, so a set wins
        next_regs[A_IFLAG] = next_regs[A_IFLAG] | (event_i & M_IFLAG);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NREG; i++)
                regs[i] <= REG_RST;
        end
        else
            regs <= next_regs;
    end

    // ---------------------------------------------------------------
    // Watchdog restart and interrupt line
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wd_clear_o <= 1'b0;
            irq_o      <= 1'b0;
        end
        else
        begin
            wd_clear_o <= commit && waddr == A_WDOG && rx_sr[WD_CLR_BIT]; // see R16
            irq_o      <= |(regs[A_IFLAG] & regs[A_IMASK]);
        end
    end

    // Register contents straight from the storage flops
    for (genvar g = 0; g < NREG; g++)
    begin : g_out
        assign regs_o[g*8 +: 8] = regs[g];
    end
endmodule : adsp_device
`default_nettype wire

// ### src/adsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module adsp_host import adsp_pkg::*; #(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input  wire logic        clk_i,    // System clock
    input  wire logic        rst_i,    // Synchronous reset
    input  wire logic        wb_cyc_i, // Wishbone cycle
    input  wire logic        wb_stb_i, // Wishbone strobe
    input  wire logic        wb_we_i,  // Write enable
    input  wire logic [3:0]  wb_adr_i, // Byte address
    input  wire logic [3:0]  wb_sel_i, // Byte lanes
    input  wire logic [31:0] wb_dat_i, // Write data
    output logic      [31:0] wb_dat_o, // Read data
    output logic             wb_ack_o, // Acknowledge
    output logic             irq_o,    // Frame-done interrupt
    adsp_if.host             link      // Serial link
);
    typedef enum logic [5:0] {
        HS_IDLE  = 6'b000001,
        HS_LEAD  = 6'b000010,
        HS_HIGH  = 6'b000100,
        HS_LOW   = 6'b001000,
        HS_TRAIL = 6'b010000,
        HS_GAP   = 6'b100000
    } adsp_hstate_t;

    adsp_hstate_t state;
    logic [15:0]  div, tx_sr, rx_sr, result;
    logic [4:0]   bit_cnt;
    logic         tick, miso_s, wr, start, done, istat, imask;

    assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign start = wr && wb_adr_i == H_CMD && (&wb_sel_i[1:0]) && state == HS_IDLE;
    assign done  = (state == HS_GAP) && tick;
    assign tick  = (div == 16'h0000);

    adsp_sync #(.W(1), .INIT(1'b0)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (link.miso_line),
        .q_o   (miso_s)
    );

    // ---------------------------------------------------------------
    // Half-period divider; restarts with each frame
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start || tick)
            div <= 16'(HALF_CYC - 1);
        else
            div <= div - 16'h0001;
    end

    // ---------------------------------------------------------------
    // Frame sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state     <= HS_IDLE;
            link.ss_n <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
            tx_sr     <= 16'h0000;
            rx_sr     <= 16'h0000;
            bit_cnt   <= 5'h00;
        end
        else
        begin
            case (state)
                HS_IDLE:
                    if (start)
                    begin
                        // Even parity over direction and address; see R12 see R17
                        tx_sr <= {wb_dat_i[CMD_RW_BIT], wb_dat_i[CMD_ADDR_LSB+4:CMD_ADDR_LSB],
                                  ^wb_dat_i[CMD_RW_BIT:CMD_ADDR_LSB], 1'b0, wb_dat_i[7:0]};
                        link.ss_n <= 1'b0;
                        bit_cnt   <= 5'h00;
                        state     <= HS_LEAD;
                    end
                HS_LEAD, HS_LOW:
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        link.mosi <= tx_sr[15]; // see R3
                        tx_sr     <= {tx_sr[14:0], 1'b0};
                        state     <= HS_HIGH;
                    end
                HS_HIGH:
                    if (tick)
                    begin
                        link.sclk <= 1'b0;
                        rx_sr     <= {rx_sr[14:0], miso_s}; // see R4
                        bit_cnt   <= bit_cnt + 5'h01;
                        // Exactly sixteen falling edges per frame; see R1 see R5
                        state <= (bit_cnt == 5'(FRAME_BITS - 1)) ? HS_TRAIL : HS_LOW;
                    end
                HS_TRAIL:
                    if (tick)
                    begin
                        link.ss_n <= 1'b1;
                        state     <= HS_GAP;
                    end
                HS_GAP:
                    if (tick)
                        state <= HS_IDLE;
                default:
                    state <= HS_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Result, interrupt status and mask
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            result <= 16'h0000;
            istat  <= 1'b0;
            imask  <= 1'b0;
            irq_o  <= 1'b0;
        end
        else
        begin
            if (done)
                result <= rx_sr;
            // Set wins over a simultaneous write-one clear
            if (done)
                istat <= 1'b1;
            else if (wr && wb_adr_i == H_ISTAT && wb_sel_i[0] && wb_dat_i[0])
                istat <= 1'b0;
            if (wr && wb_adr_i == H_IMASK && wb_sel_i[0])
                imask <= wb_dat_i[0];
            irq_o <= istat & imask;
        end
    end

    // ---------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped reads zero
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_adr_i == H_STAT)
                wb_dat_o <= {15'h0000, state != HS_IDLE, result};
            else if (wb_adr_i == H_ISTAT)
                wb_dat_o <= {31'h0000_0000, istat};
            else if (wb_adr_i == H_IMASK)
                wb_dat_o <= {31'h0000_0000, imask};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end
endmodule : adsp_host
`default_nettype wire

// ### verif/adsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adsp_assertions #(
    parameter int HALF = 8
) (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Reset
    input wire logic ss_n,   // Select
    input wire logic sclk,   // Serial clock
    input wire logic mosi,   // Host data
    input wire logic miso,   // Device data
    input wire logic miso_oe // Device drive
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] n_fall;
    logic [7:0] run;
    logic       sclk_q;
    // ----
    // Helpers
    // ----
    // Sampling edges seen in this frame
    always_ff @(posedge clk_i)
    begin
        if (rst_i || ss_n)
            n_fall <= 5'h00;
        else if (sclk_q && !sclk)
            n_fall <= n_fall + 5'h01;
    end
    // Cycles the serial clock has held its level
    always_ff @(posedge clk_i)
    begin
        sclk_q <= sclk;
        if (sclk != sclk_q)
            run <= 8'h01;
        else if (run != 8'hff)
            run <= run + 8'h01;
    end
    sequence s_oe_up;
        ##[1:6] miso_oe;
    endsequence
    sequence s_oe_down;
        ##[1:6] !miso_oe;
    endsequence
    // ----
    // Checks
    // ----
    a_oe_on_start: assert property ($fell(ss_n) |-> s_oe_up)
        else $error("miso not driven after select fall");
    a_oe_off_end: assert property ($rose(ss_n) |-> s_oe_down)
        else $error("miso still driven after select rise");
    a_oe_off_idle: assert property (ss_n [*7] |-> !miso_oe)
        else $error("miso driven while idle");
    // Settle slack: the first bit may be cleared just after drive starts
    a_miso_on_rise: assert property (($changed(miso) && $past(miso_oe, 2) && !ss_n) |-> sclk)
        else $error("miso changed away from a rising edge");
    a_mosi_on_rise: assert property (($changed(mosi) && !ss_n) |-> $rose(sclk))
        else $error("mosi changed away from a rising edge");
    a_sclk_idle: assert property (ss_n |-> !sclk)
        else $error("serial clock runs outside a frame");
    a_sixteen_falls: assert property ($rose(ss_n) |-> n_fall == 5'h10)
        else $error("frame without sixteen sampling edges");
    a_half_period: assert property ($fell(sclk) |-> (run == 8'(HALF) && !ss_n))
        else $error("serial clock high phase wrong");
endmodule : adsp_assertions
`default_nettype wire

// ### verif/analog_die_spi_register_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module analog_die_spi_register_port_test import adsp_pkg::*;;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq_h, irq_a, wd;
    logic [3:0]        adr = 4'h0;
    logic [31:0]       dw = 32'h0, dr, q;
    logic [7:0]        ev = 8'h00, sflag = 8'hff, hsf = 8'h87;
    logic [15:0]       r;
    logic [NUM_REGS*8-1:0] regs_a, regs_b;
    int                n_fail = 0, num_checks = 0, cyc_n = 0, n_wd = 0;
    // Address, write data, old value, read value
    logic [31:0] tab [10] = '{32'h01a500a5, 32'h05ff0000, 32'h04ff8787, 32'h10ff0000,
        32'h0fff00c0, 32'h0be100e0, 32'h09ff00ff, 32'h013ca53c, 32'h00ff009f, 32'h0cff9e9e};
    adsp_if lk ();
    adsp_if lk_b ();
    adsp_host i_adsp_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .irq_o(irq_h), .link(lk.host));
    adsp_device i_adsp_device (.clk_i(clk_i), .rst_i(rst_i), .link(lk.dev), .event_i(ev),
        .sys_flag_i(sflag), .hs_flag_i(hsf), .regs_o(regs_a), .wd_clear_o(wd), .irq_o(irq_a));
    // Second device faces the bench driver that breaks link rules
    adsp_device i_adsp_device_b (.clk_i(clk_i), .rst_i(rst_i), .link(lk_b.dev),
        .event_i(8'h00), .sys_flag_i(sflag), .hs_flag_i(hsf), .regs_o(regs_b),
        .wd_clear_o(), .irq_o());
    adsp_assertions #(.HALF(SCLK_HALF_CYC)) i_adsp_assertions (.clk_i(clk_i), .rst_i(rst_i),
        .ss_n(lk.ss_n), .sclk(lk.sclk), .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
    // Clock, hang limit and watchdog pulse count
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (wd === 1'b1)
            n_wd++;
        if (cyc_n == 30000)
        begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One classic Wishbone cycle, held until ack
    task automatic wbx(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wbx
    // Frame through the host; e is status byte then data byte
    task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d,
                        input logic [15:0] e);
        wbx(1'b1, H_CMD, {18'h0, rw, a, d});
        q = 32'h0001_0000;
        while (q[ST_BUSY_BIT] !== 1'b0)
            wbx(1'b0, H_STAT, 32'h0);
        chk(32'(q[15:0]), 32'(e));
    endtask : xfer
    function automatic logic [31:0] fw(logic rw, logic [4:0] a, logic [7:0] d, logic bad,
                                       logic sp);
        return {rw, a, ^{rw, a} ^ bad, sp, d, 16'h0};
    endfunction : fw
    // Bench-driven frame of n bits; unused line held low like its pull-down
    task automatic bang(input logic [31:0] w, input int n);
        r = 16'h0;
        @(posedge clk_i);
        lk_b.ss_n <= 1'b0;
        repeat (SCLK_HALF_CYC) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            lk_b.sclk <= 1'b1;
            lk_b.mosi <= w[31-i];
            repeat (SCLK_HALF_CYC) @(posedge clk_i);
            lk_b.sclk <= 1'b0;
            r = {r[14:0], lk_b.miso_line};
            repeat (SCLK_HALF_CYC) @(posedge clk_i);
        end
        lk_b.ss_n <= 1'b1;
        lk_b.mosi <= 1'b0;
        repeat (16) @(posedge clk_i);
    endtask : bang
    initial
    begin
        lk_b.ss_n = 1'b1;
        lk_b.sclk = 1'b0;
        lk_b.mosi = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wbx(1'b0, 4'h6, 32'h0);
        chk(q, 32'h0);
        xfer(1'b1, A_STATUS, 8'h00, 16'h9e9e);
        chk(32'(irq_h), 32'h0);
        wbx(1'b1, H_IMASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_h), 32'h1);
        wbx(1'b1, H_ISTAT, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_h), 32'h0);
        $display("test host done");
        // Each table entry written, then read back
        foreach (tab[k])
        begin
            xfer(1'b0, tab[k][28:24], tab[k][23:16], {8'h9e, tab[k][15:8]});
            xfer(1'b1, tab[k][28:24], 8'h55, {8'h9e, tab[k][7:0]});
        end
        chk(32'(regs_a[A_HBDRV*8+:8]), 32'h3c);
        chk(32'(n_wd), 32'h1);
        $display("test registers done");
        // Flag raised, cleared, then masked
        ev <= 8'h08;
        @(posedge clk_i);
        ev <= 8'h00;
        repeat (3) @(posedge clk_i);
        chk(32'(irq_a), 32'h1);
        xfer(1'b0, A_IFLAG, 8'h08, 16'hde08);
        repeat (3) @(posedge clk_i);
        chk(32'(irq_a), 32'h0);
        xfer(1'b0, A_IMASK, 8'h00, 16'h9eff);
        ev <= 8'h02;
        @(posedge clk_i);
        ev <= 8'h00;
        repeat (3) @(posedge clk_i);
        chk(32'(irq_a), 32'h0);
        xfer(1'b1, A_IFLAG, 8'h00, 16'hbe02);
        $display("test interrupts done");
        // Good and faulty frames on the second link
        bang(fw(1'b0, A_HBDRV, 8'ha5, 1'b0, 1'b0), 16);
        chk(32'(r), 32'h9e00);
        chk(32'(regs_b[15:8]), 32'ha5);
        bang(fw(1'b0, A_HSDRV, 8'h0f, 1'b1, 1'b0), 16);
        bang(fw(1'b0, A_HSDRV, 8'h0f, 1'b0, 1'b0), 15);
        bang(fw(1'b0, A_HSDRV, 8'h0f, 1'b0, 1'b0), 17);
        chk(32'(regs_b[23:16]), 32'h0);
        bang(fw(1'b1, A_HBDRV, 8'h00, 1'b1, 1'b0), 16);
        chk(32'(r), 32'h9ea5);
        bang(fw(1'b0, A_HSDRV, 8'h0f, 1'b0, 1'b1), 16);
        chk(32'(regs_b[23:16]), 32'h0f);
        $display("test faults done");
        end_sim();
    end
endmodule : analog_die_spi_register_port_test
`default_nettype wire
